// ===== design/acft_pkg.sv
// Notes on behaviour
// - frame qualifier high across all valid lines
// - line qualifier high only during valid pixels
// - data qualifier high exactly when word valid
// - all four qualifiers driven on the link
// - unused data bits driven to zero
// - first control pair is trigger; rest ignored
// - serial frames: start, eight bits, stop
// - serial rate at least 9600 baud
// - separate serial pair in each direction
// - grabber holds trigger pulse at least 12 us
// - normal-mode pulse at least 10 us
// - sensor-timed mode needs longer trigger pulse
// - frame starts no sooner than 65.2 us
// - frame high for the readout of all lines
// - grabber waits 43 us after frame end
// - triggers spaced at least 9.81 ms apart
// - first line starts 20 strobes after frame
// - frame and last line fall together
// - line qualifier low at least 0.64 us
package acft_pkg;

	localparam real LINK_PERIOD_NS = 30.0;
	localparam real SYS_PERIOD_NS  = 8.0;
	localparam real T_TRANSFER_US  = 65.2;
	localparam real T_OVERHEAD_US  = 43.0;
	localparam real T_GAP_US       = 0.64;
	localparam real T_LINE_MIN_US  = 0.436;
	localparam real T_LINE_MAX_US  = 8.8;
	localparam real T_SYNC_US      = 12.0;
	localparam real T_SYNC_INT_US  = 10.0;
	localparam real T_FRAME_MS     = 9.81;
	localparam real BAUD_RATE      = 9600.0;

	// least time rounded up to whole cycles
	function automatic int cyc_min(real ns, real per);
		return int'($ceil(ns / per));
	endfunction : cyc_min

	// longest time rounded down, never below one
	function automatic int cyc_max(real ns, real per);
		int c;
		c = int'($floor(ns / per));
		return (c < 1) ? 1 : c;
	endfunction : cyc_max

	// link-domain counts, camera side
	localparam logic [15:0] TRANSFER_CYC =
		16'(cyc_min(T_TRANSFER_US * 1000.0, LINK_PERIOD_NS));
	localparam logic [15:0] OVERHEAD_CYC =
		16'(cyc_min(T_OVERHEAD_US * 1000.0, LINK_PERIOD_NS));
	localparam logic [15:0] GAP_CYC =
		16'(cyc_min(T_GAP_US * 1000.0, LINK_PERIOD_NS));
	localparam logic [15:0] LINE_MIN_CYC =
		16'(cyc_min(T_LINE_MIN_US * 1000.0, LINK_PERIOD_NS));
	localparam logic [15:0] LINE_MAX_CYC =
		16'(cyc_max(T_LINE_MAX_US * 1000.0, LINK_PERIOD_NS));
	localparam logic [15:0] SYNC_SMART_CYC =
		16'(cyc_min(T_SYNC_US * 1000.0, LINK_PERIOD_NS));
	localparam logic [15:0] SYNC_NORM_CYC =
		16'(cyc_min(T_SYNC_INT_US * 1000.0, LINK_PERIOD_NS));
	localparam logic [15:0] FL_STROBES   = 16'h0014;
	localparam logic [15:0] ACT_MAX      = LINE_MAX_CYC - GAP_CYC;
	localparam logic [15:0] ACT_MIN      = 16'h0001;

	// system-domain counts, grabber side and serial
	localparam logic [15:0] SYNC_SYS_CYC =
		16'(cyc_min(T_SYNC_US * 1000.0, SYS_PERIOD_NS));
	localparam int OVERHEAD_SYS_CYC =
		cyc_min(T_OVERHEAD_US * 1000.0, SYS_PERIOD_NS);
	localparam int FRAME_SYS_CYC =
		cyc_min(T_FRAME_MS * 1000000.0, SYS_PERIOD_NS);
	localparam int BAUD_CYC =
		cyc_max(1000000000.0 / BAUD_RATE, SYS_PERIOD_NS);

	// link layout and configuration reset values
	localparam int          DATA_W       = 24;
	localparam int          CC_W         = 4;
	localparam int          LINES_W      = 11;
	localparam int          ACT_W        = 9;
	localparam logic [10:0] CFG_LINES_RST = 11'h400;
	localparam logic [8:0]  CFG_ACT_RST   = 9'h0AF;

	typedef enum logic [5:0] {
		CS_IDLE = 6'h01,
		CS_XFER = 6'h02,
		CS_LEAD = 6'h04,
		CS_LINE = 6'h08,
		CS_GAP  = 6'h10,
		CS_OVH  = 6'h20
	} acft_cam_st_t;

	typedef enum logic [1:0] {
		GS_IDLE  = 2'h1,
		GS_PULSE = 2'h2
	} acft_grb_st_t;

endpackage : acft_pkg

// ===== design/acft_link_if.sv
`timescale 1ns/1ps
interface acft_link_if (
	input wire logic clk_link
);
	logic                      frame_valid_qualifier;
	logic                      line_valid_qualifier;
	logic                      data_valid_qualifier;
	logic                      spare_qualifier;
	logic [acft_pkg::DATA_W-1:0] video_data;
	logic [acft_pkg::CC_W-1:0]   control_pairs;
	logic                      serial_to_grabber;
	logic                      serial_to_camera_pair;

	modport camera (
		input  clk_link,
		input  control_pairs,
		input  serial_to_camera_pair,
		output frame_valid_qualifier,
		output line_valid_qualifier,
		output data_valid_qualifier,
		output spare_qualifier,
		output video_data,
		output serial_to_grabber
	);

	modport grabber (
		input  clk_link,
		input  frame_valid_qualifier,
		input  line_valid_qualifier,
		input  data_valid_qualifier,
		input  spare_qualifier,
		input  video_data,
		input  serial_to_grabber,
		output control_pairs,
		output serial_to_camera_pair
	);
endinterface : acft_link_if

// ===== design/acft_camera.sv
`timescale 1ns/1ps
module acft_camera #(
	parameter int BAUD_DIV  = acft_pkg::BAUD_CYC,
	parameter int MAX_LINES = 1024
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_cfg_load,
	input  wire logic [10:0] i_cfg_lines,
	input  wire logic [8:0]  i_cfg_act,
	input  wire logic        i_cfg_ten_bit,
	input  wire logic        i_cfg_smart,
	output logic             o_cfg_busy,
	output logic             o_frame_done,
	output logic             o_trig_dropped,
	input  wire logic [7:0]  i_tx_data,
	input  wire logic        i_tx_valid,
	output logic             o_tx_ready,
	output logic [7:0]       o_rx_data,
	output logic             o_rx_valid,
	acft_link_if.camera      lk
);

	////////////////////////////////////////////////////////////////////
	// system side: configuration handshake
	logic [10:0] cfg_lines;
	logic [8:0]  cfg_act;
	logic        cfg_ten;
	logic        cfg_smart;
	logic        cfg_req;
	logic        ack_m;
	logic        ack_s;
	logic        req_d;

	assign o_cfg_busy = cfg_req ^ ack_s;

	// bundle held still until the link side echoes the toggle
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			cfg_lines <= acft_pkg::CFG_LINES_RST;
			cfg_act   <= acft_pkg::CFG_ACT_RST;
			cfg_ten   <= 1'b0;
			cfg_smart <= 1'b0;
			cfg_req   <= 1'b0;
		end else if (i_cfg_load && !o_cfg_busy) begin
			cfg_lines <= i_cfg_lines;
			cfg_act   <= i_cfg_act;
			cfg_ten   <= i_cfg_ten_bit;
			cfg_smart <= i_cfg_smart;
			cfg_req   <= ~cfg_req;
		end
	end

	// events back from the link side, toggle to pulse
	logic frm_tgl;
	logic drp_tgl;
	logic [2:0] frm_sy;
	logic [2:0] drp_sy;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			ack_m  <= 1'b0;
			ack_s  <= 1'b0;
			frm_sy <= 3'h0;
			drp_sy <= 3'h0;
		end else begin
			ack_m  <= req_d;
			ack_s  <= ack_m;
			frm_sy <= {frm_sy[1:0], frm_tgl};
			drp_sy <= {drp_sy[1:0], drp_tgl};
		end
	end

	assign o_frame_done   = frm_sy[2] ^ frm_sy[1];
	assign o_trig_dropped = drp_sy[2] ^ drp_sy[1];

	////////////////////////////////////////////////////////////////////
	// serial port, one start bit, eight data, one stop, no parity
	logic [9:0]  tx_sh;
	logic [3:0]  tx_bits;
	logic [15:0] tx_div;
	logic        rx_m;
	logic        rx_s;
	logic [8:0]  rx_sh;
	logic [3:0]  rx_bits;
	logic [15:0] rx_div;
	wire  [15:0] baud_top = 16'(BAUD_DIV - 1);

	assign o_tx_ready = (tx_bits == 4'h0);
	assign lk.serial_to_grabber = tx_sh[0];

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			tx_sh   <= 10'h3FF;
			tx_bits <= 4'h0;
			tx_div  <= 16'h0000;
		end else if (o_tx_ready) begin
			if (i_tx_valid) begin
				tx_sh   <= {1'b1, i_tx_data, 1'b0};
				tx_bits <= 4'hA;
				tx_div  <= baud_top;
			end
		end else if (tx_div == 16'h0000) begin
			tx_sh   <= {1'b1, tx_sh[9:1]};
			tx_bits <= tx_bits - 4'h1;
			tx_div  <= baud_top;
		end else begin
			tx_div <= tx_div - 16'h0001;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			rx_m       <= 1'b1;
			rx_s       <= 1'b1;
			rx_sh      <= 9'h000;
			rx_bits    <= 4'h0;
			rx_div     <= 16'h0000;
			o_rx_data  <= 8'h00;
			o_rx_valid <= 1'b0;
		end else begin
			rx_m       <= lk.serial_to_camera_pair;
			rx_s       <= rx_m;
			o_rx_valid <= 1'b0;
			if (rx_bits == 4'h0) begin
				if (!rx_s) begin
					rx_bits <= 4'hA;
					rx_div  <= {1'b0, baud_top[15:1]};
				end
			end else if (rx_div != 16'h0000) begin
				rx_div <= rx_div - 16'h0001;
			end else if (rx_bits == 4'hA && rx_s) begin
				rx_bits <= 4'h0; // false start
			end else if (rx_bits == 4'h1) begin
				rx_bits    <= 4'h0;
				o_rx_data  <= rx_sh[8:1];
				o_rx_valid <= rx_s; // stop bit must be high
			end else begin
				rx_sh   <= {rx_s, rx_sh[8:1]};
				rx_bits <= rx_bits - 4'h1;
				rx_div  <= baud_top;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// link side: reset, configuration capture, trigger
	logic        rst_m;
	logic        rst_l;
	logic [2:0]  req_sy;
	logic [10:0] lk_lines;
	logic [8:0]  lk_act;
	logic        lk_ten;
	logic        lk_smart;
	logic        trg_m;
	logic        trg_s;
	logic        trg_d;
	logic [15:0] hi_cnt;

	function automatic logic [15:0] clamp(logic [15:0] v,
			logic [15:0] lo, logic [15:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp

	always_ff @(posedge lk.clk_link) begin
		rst_m <= i_rst;
		rst_l <= rst_m;
	end

	assign req_d = req_sy[2];

	always_ff @(posedge lk.clk_link) begin
		if (rst_l) begin
			req_sy   <= 3'h0;
			lk_lines <= acft_pkg::CFG_LINES_RST;
			lk_act   <= acft_pkg::CFG_ACT_RST;
			lk_ten   <= 1'b0;
			lk_smart <= 1'b0;
		end else begin
			req_sy <= {req_sy[1:0], cfg_req};
			if (req_sy[2] ^ req_sy[1]) begin
				lk_lines <= cfg_lines;
				lk_act   <= cfg_act;
				lk_ten   <= cfg_ten;
				lk_smart <= cfg_smart;
			end
		end
	end

	// only the first control pair is read
	always_ff @(posedge lk.clk_link) begin
		if (rst_l) begin
			trg_m  <= 1'b0;
			trg_s  <= 1'b0;
			trg_d  <= 1'b0;
			hi_cnt <= 16'h0000;
		end else begin
			trg_m  <= lk.control_pairs[0];
			trg_s  <= trg_m;
			trg_d  <= trg_s;
			hi_cnt <= !trg_s ? 16'h0000 :
				(&hi_cnt ? hi_cnt : hi_cnt + 16'h0001);
		end
	end

	////////////////////////////////////////////////////////////////////
	// frame sequencer
	acft_pkg::acft_cam_st_t st;
	acft_pkg::acft_cam_st_t next_st;
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic [10:0] left;
	logic [10:0] next_left;
	logic [15:0] run_act;
	logic        run_ten;
	logic [9:0]  pix;

	// sensor-timed mode asks the longer pulse
	wire [15:0] min_w = lk_smart ? acft_pkg::SYNC_SMART_CYC
		: acft_pkg::SYNC_NORM_CYC;
	wire trg_fall = trg_d & ~trg_s;
	// early or short trigger is refused
	wire accept   = trg_fall && (st == acft_pkg::CS_IDLE)
		&& (hi_cnt >= min_w);
	wire cnt_done = (cnt == 16'h0000);
	// active length keeps line time in range
	wire [15:0] act_c = clamp({7'h00, lk_act},
		acft_pkg::ACT_MIN, acft_pkg::ACT_MAX);
	wire [15:0] lin_c = clamp({5'h00, lk_lines},
		16'h0001, 16'(MAX_LINES));
	wire in_frame = (next_st == acft_pkg::CS_LEAD)
		|| (next_st == acft_pkg::CS_LINE)
		|| (next_st == acft_pkg::CS_GAP);
	wire in_line  = (next_st == acft_pkg::CS_LINE);

	always_comb begin
		next_st   = st;
		next_cnt  = cnt - 16'h0001;
		next_left = left;
		case (st)
			acft_pkg::CS_IDLE: begin
				next_cnt  = acft_pkg::TRANSFER_CYC - 16'h0001;
				next_left = lin_c[10:0];
				if (accept) begin
					next_st = acft_pkg::CS_XFER;
				end
			end
			acft_pkg::CS_XFER: begin
				if (cnt_done) begin
					next_st  = acft_pkg::CS_LEAD;
					next_cnt = acft_pkg::FL_STROBES - 16'h0001;
				end
			end
			acft_pkg::CS_LEAD, acft_pkg::CS_GAP: begin
				if (cnt_done) begin
					next_st  = acft_pkg::CS_LINE;
					next_cnt = run_act - 16'h0001;
				end
			end
			acft_pkg::CS_LINE: begin
				if (cnt_done && left == 11'h001) begin
					next_st  = acft_pkg::CS_OVH;
					next_cnt = acft_pkg::OVERHEAD_CYC - 16'h0001;
				end else if (cnt_done) begin
					next_st   = acft_pkg::CS_GAP;
					next_cnt  = acft_pkg::GAP_CYC - 16'h0001;
					next_left = left - 11'h001;
				end
			end
			acft_pkg::CS_OVH: begin
				if (cnt_done) begin
					next_st = acft_pkg::CS_IDLE;
				end
			end
			default: begin
				next_st = acft_pkg::CS_IDLE;
			end
		endcase
	end

	// two taps of consecutive pixels, unused bits zero
	function automatic logic [23:0] fmt(logic ten, logic [9:0] a);
		logic [9:0] b;
		b = a + 10'h001;
		return ten ? {b[7:0], 2'b00, b[9:8], 2'b00, a[9:8], a[7:0]}
			: {8'h00, b[7:0], a[7:0]};
	endfunction : fmt

	always_ff @(posedge lk.clk_link) begin
		if (rst_l) begin
			st      <= acft_pkg::CS_IDLE;
			cnt     <= 16'h0000;
			left    <= 11'h000;
			run_act <= 16'h0001;
			run_ten <= 1'b0;
			pix     <= 10'h000;
			frm_tgl <= 1'b0;
			drp_tgl <= 1'b0;
		end else begin
			st   <= next_st;
			cnt  <= next_cnt;
			left <= next_left;
			// geometry frozen for the whole frame
			if (accept) begin
				run_act <= act_c;
				run_ten <= lk_ten;
			end
			pix <= in_line ? pix + 10'h002
				: (next_st == acft_pkg::CS_LEAD ? 10'h000 : pix);
			if (st == acft_pkg::CS_LINE && next_st == acft_pkg::CS_OVH) begin
				frm_tgl <= ~frm_tgl;
			end
			if (trg_fall && !accept) begin
				drp_tgl <= ~drp_tgl;
			end
		end
	end

	// qualifiers and data from one set of flops
	always_ff @(posedge lk.clk_link) begin
		if (rst_l) begin
			lk.frame_valid_qualifier <= 1'b0;
			lk.line_valid_qualifier  <= 1'b0;
			lk.data_valid_qualifier  <= 1'b0;
			lk.spare_qualifier       <= 1'b0;
			lk.video_data            <= 24'h000000;
		end else begin
			lk.frame_valid_qualifier <= in_frame;
			lk.line_valid_qualifier  <= in_line;
			lk.data_valid_qualifier  <= in_line;
			lk.spare_qualifier       <= 1'b0;
			// idle and unused bits forced low
			lk.video_data <= in_line ? fmt(run_ten, pix) : 24'h000000;
		end
	end

endmodule : acft_camera

// ===== design/acft_grabber.sv
`timescale 1ns/1ps
module acft_grabber #(
	parameter int BAUD_DIV     = acft_pkg::BAUD_CYC,
	parameter int OVERHEAD_CYC = acft_pkg::OVERHEAD_SYS_CYC,
	parameter int FRAME_CYC    = acft_pkg::FRAME_SYS_CYC
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_trig_req,
	input  wire logic [15:0] i_trig_width,
	output logic             o_trig_ready,
	input  wire logic [7:0]  i_tx_data,
	input  wire logic        i_tx_valid,
	output logic             o_tx_ready,
	output logic [7:0]       o_rx_data,
	output logic             o_rx_valid,
	output logic [23:0]      o_vid_data,
	output logic             o_vid_valid,
	output logic             o_vid_sof,
	output logic             o_vid_eof,
	acft_link_if.grabber     lk
);

	////////////////////////////////////////////////////////////////////
	// trigger generator on the system clock
	acft_pkg::acft_grb_st_t st;
	logic        trg;
	logic [15:0] w_cnt;
	logic [20:0] per_cnt;
	logic [20:0] ovh_cnt;
	logic [2:0]  fv_sy;

	wire [15:0] width = (i_trig_width < acft_pkg::SYNC_SYS_CYC)
		? acft_pkg::SYNC_SYS_CYC : i_trig_width;
	wire fv_fall = fv_sy[2] & ~fv_sy[1];

	// ready after both waits, never in the fall cycle
	// (the overhead count only loads one edge after the frame drops)
	assign o_trig_ready = (st == acft_pkg::GS_IDLE)
		&& (per_cnt == 21'h000000) && (ovh_cnt == 21'h000000)
		&& !fv_sy[1] && !fv_sy[2];
	// trigger on first pair, others held low
	assign lk.control_pairs = {3'b000, trg};

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			fv_sy   <= 3'h0;
			ovh_cnt <= 21'h000000;
		end else begin
			fv_sy <= {fv_sy[1:0], lk.frame_valid_qualifier};
			if (fv_fall) begin
				ovh_cnt <= 21'(OVERHEAD_CYC - 1);
			end else if (ovh_cnt != 21'h000000) begin
				ovh_cnt <= ovh_cnt - 21'h000001;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			st      <= acft_pkg::GS_IDLE;
			trg     <= 1'b0;
			w_cnt   <= 16'h0000;
			per_cnt <= 21'h000000;
		end else begin
			case (st)
				acft_pkg::GS_IDLE: begin
					if (per_cnt != 21'h000000) begin
						per_cnt <= per_cnt - 21'h000001;
					end
					if (i_trig_req && o_trig_ready) begin
						st    <= acft_pkg::GS_PULSE;
						trg   <= 1'b1;
						w_cnt <= width - 16'h0001;
					end
				end
				acft_pkg::GS_PULSE: begin
					w_cnt <= w_cnt - 16'h0001;
					if (w_cnt == 16'h0000) begin
						st      <= acft_pkg::GS_IDLE;
						trg     <= 1'b0;
						per_cnt <= 21'(FRAME_CYC - 1);
					end
				end
				default: begin
					st  <= acft_pkg::GS_IDLE;
					trg <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// serial port, one start bit, eight data, one stop, no parity
	logic [9:0]  tx_sh;
	logic [3:0]  tx_bits;
	logic [15:0] tx_div;
	logic        rx_m;
	logic        rx_s;
	logic [8:0]  rx_sh;
	logic [3:0]  rx_bits;
	logic [15:0] rx_div;
	wire  [15:0] baud_top = 16'(BAUD_DIV - 1);

	assign o_tx_ready = (tx_bits == 4'h0);
	assign lk.serial_to_camera_pair = tx_sh[0];

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			tx_sh   <= 10'h3FF;
			tx_bits <= 4'h0;
			tx_div  <= 16'h0000;
		end else if (o_tx_ready) begin
			if (i_tx_valid) begin
				tx_sh   <= {1'b1, i_tx_data, 1'b0};
				tx_bits <= 4'hA;
				tx_div  <= baud_top;
			end
		end else if (tx_div == 16'h0000) begin
			tx_sh   <= {1'b1, tx_sh[9:1]};
			tx_bits <= tx_bits - 4'h1;
			tx_div  <= baud_top;
		end else begin
			tx_div <= tx_div - 16'h0001;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			rx_m       <= 1'b1;
			rx_s       <= 1'b1;
			rx_sh      <= 9'h000;
			rx_bits    <= 4'h0;
			rx_div     <= 16'h0000;
			o_rx_data  <= 8'h00;
			o_rx_valid <= 1'b0;
		end else begin
			rx_m       <= lk.serial_to_grabber;
			rx_s       <= rx_m;
			o_rx_valid <= 1'b0;
			if (rx_bits == 4'h0) begin
				if (!rx_s) begin
					rx_bits <= 4'hA;
					rx_div  <= {1'b0, baud_top[15:1]};
				end
			end else if (rx_div != 16'h0000) begin
				rx_div <= rx_div - 16'h0001;
			end else if (rx_bits == 4'hA && rx_s) begin
				rx_bits <= 4'h0; // false start
			end else if (rx_bits == 4'h1) begin
				rx_bits    <= 4'h0;
				o_rx_data  <= rx_sh[8:1];
				o_rx_valid <= rx_s;
			end else begin
				rx_sh   <= {rx_s, rx_sh[8:1]};
				rx_bits <= rx_bits - 4'h1;
				rx_div  <= baud_top;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// video capture on the link clock
	logic rst_m;
	logic rst_l;
	logic fv_q;
	logic first;

	wire word_ok = lk.frame_valid_qualifier & lk.line_valid_qualifier
		& lk.data_valid_qualifier;

	always_ff @(posedge lk.clk_link) begin
		rst_m <= i_rst;
		rst_l <= rst_m;
	end

	always_ff @(posedge lk.clk_link) begin
		if (rst_l) begin
			fv_q        <= 1'b0;
			first       <= 1'b0;
			o_vid_data  <= 24'h000000;
			o_vid_valid <= 1'b0;
			o_vid_sof   <= 1'b0;
			o_vid_eof   <= 1'b0;
		end else begin
			fv_q        <= lk.frame_valid_qualifier;
			o_vid_data  <= lk.video_data;
			o_vid_valid <= word_ok;
			o_vid_sof   <= word_ok & first;
			o_vid_eof   <= fv_q & ~lk.frame_valid_qualifier;
			if (lk.frame_valid_qualifier & ~fv_q) begin
				first <= 1'b1;
			end else if (word_ok) begin
				first <= 1'b0;
			end
		end
	end

endmodule : acft_grabber

// ===== tb/acft_asserts.sv
`timescale 1ns/1ps
module acft_asserts (
	input wire logic        clk_link,
	input wire logic        i_rst,
	input wire logic        frame_valid_qualifier,
	input wire logic        line_valid_qualifier,
	input wire logic        data_valid_qualifier,
	input wire logic        spare_qualifier,
	input wire logic [23:0] video_data,
	input wire logic [3:0]  control_pairs
);
	wire         fv = frame_valid_qualifier;
	wire         lv = line_valid_qualifier;
	wire         tg = control_pairs[0];
	logic [15:0] fcnt, gcnt, tcnt, hcnt;
	logic        seen, tg_q;

	// strobes into frame, gap length, trigger age and width
	always_ff @(posedge clk_link) begin
		tg_q <= tg;
		seen <= fv & (seen | lv);
		fcnt <= fv ? fcnt + 16'h0001 : 16'h0000;
		gcnt <= lv ? 16'h0000 : gcnt + 16'h0001;
		hcnt <= tg ? hcnt + 16'h0001 : 16'h0000;
		tcnt <= (tg_q & !tg) ? 16'h0000 : tcnt + 16'h0001;
	end

	default clocking cb @(posedge clk_link); endclocking
	default disable iff (i_rst);

	chk_line_in_frame: assert property (lv |-> fv)
		else $error("line high outside frame");
	chk_data_line: assert property (data_valid_qualifier == lv)
		else $error("data qualifier differs from line");
	chk_spare_low: assert property (!spare_qualifier)
		else $error("spare qualifier high");
	chk_unused_zero: assert property (
		!lv |-> video_data == 24'h000000)
		else $error("data not zero outside line");
	chk_pairs_idle: assert property (control_pairs[3:1] == 3'h0)
		else $error("reserved control pair driven");
	chk_lead_strobes: assert property (
		$rose(lv) && !seen |-> fcnt == acft_pkg::FL_STROBES)
		else $error("first line not 20 strobes in");
	chk_joint_fall: assert property ($fell(fv) |-> $fell(lv))
		else $error("frame fell apart from line");
	chk_gap_min: assert property (
		$rose(lv) && seen |-> gcnt >= acft_pkg::GAP_CYC)
		else $error("interline gap too short");
	chk_transfer_min: assert property (
		$rose(fv) |-> tcnt >= acft_pkg::TRANSFER_CYC)
		else $error("frame rose too soon");
	// one strobe lost to sampling the slower clock
	chk_trig_width: assert property (
		$fell(tg) |-> hcnt >= acft_pkg::SYNC_SMART_CYC - 16'h0001)
		else $error("trigger pulse too short");

	cov_frame: cover property ($rose(fv));
	cov_gap: cover property ($fell(lv) && fv);
	cov_trig: cover property ($fell(tg));
endmodule : acft_asserts

// ===== tb/area_camera_frame_output_timing_tb.sv
`timescale 1ns/1ps
module area_camera_frame_output_timing_tb;
	logic        i_clk_sys = 1'b0;
	logic        clk_link  = 1'b0;
	logic        i_rst     = 1'b1;
	logic        load = 1'b0, ten = 1'b0, smart = 1'b0, treq = 1'b0;
	logic        ctv = 1'b0, gtv = 1'b0;
	logic [10:0] lines = 11'h001;
	logic [8:0]  act = 9'h001;
	logic [15:0] tw = 16'h05DC;
	logic [7:0]  txd = 8'h00, crl, grl, crd, grd;
	logic        busy, done, drop, ctr, crv, gtr, grv, trdy, vv, sof, eof;
	logic [23:0] vd;
	int          fails = 0, n_tests = 0, cyc = 0, e_len = 0, e_px = 0;
	int          pix = 0, gpix = 0, flen = 0, nval = 0, nfr = 0;
	int          nrx = 0, ndrop = 0, neof = 0;

	always #4 i_clk_sys = ~i_clk_sys;
	always #15 clk_link = ~clk_link;

	acft_link_if lk (.clk_link(clk_link));
	acft_camera #(.BAUD_DIV(16)) u_acft_camera (.i_clk_sys, .i_rst,
		.i_cfg_load(load), .i_cfg_lines(lines), .i_cfg_act(act),
		.i_cfg_ten_bit(ten), .i_cfg_smart(smart), .o_cfg_busy(busy),
		.o_frame_done(done), .o_trig_dropped(drop), .i_tx_data(txd),
		.i_tx_valid(ctv), .o_tx_ready(ctr), .o_rx_data(crd),
		.o_rx_valid(crv), .lk(lk.camera));
	acft_grabber #(.BAUD_DIV(16), .OVERHEAD_CYC(20), .FRAME_CYC(200))
		u_acft_grabber (.i_clk_sys, .i_rst, .i_trig_req(treq),
		.i_trig_width(tw), .o_trig_ready(trdy), .i_tx_data(txd),
		.i_tx_valid(gtv), .o_tx_ready(gtr), .o_rx_data(grd),
		.o_rx_valid(grv), .o_vid_data(vd), .o_vid_valid(vv),
		.o_vid_sof(sof), .o_vid_eof(eof), .lk(lk.grabber));
	acft_asserts u_acft_asserts (.clk_link, .i_rst,
		.frame_valid_qualifier(lk.frame_valid_qualifier),
		.line_valid_qualifier(lk.line_valid_qualifier),
		.data_valid_qualifier(lk.data_valid_qualifier),
		.spare_qualifier(lk.spare_qualifier),
		.video_data(lk.video_data), .control_pairs(lk.control_pairs));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task close_out;
		if (fails == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out

	// two pixels p and p+1 per strobe in either layout
	function automatic logic [23:0] word(input int p, input logic t);
		logic [9:0] a, b;
		a = 10'(p);
		b = 10'(p + 1);
		if (t) return {b[7:0], 2'h0, b[9:8], 2'h0, a[9:8], a[7:0]};
		return {8'h00, b[7:0], a[7:0]};
	endfunction : word

	// send one byte either way and watch its bits on the wire
	task automatic ser(input logic cam, input logic [7:0] d);
		logic [9:0] bits;
		bits = {1'h1, d, 1'h0};
		txd <= d;
		ctv <= cam;
		gtv <= !cam;
		@(posedge i_clk_sys);
		for (int i = 0; i < 400 && !(cam ? ctr : gtr); i++)
			@(posedge i_clk_sys);
		ctv <= 1'b0;
		gtv <= 1'b0;
		repeat (8) @(posedge i_clk_sys);
		for (int k = 0; k < 10; k++) begin
			check(cam ? lk.serial_to_grabber : lk.serial_to_camera_pair,
				bits[k]);
			repeat (16) @(posedge i_clk_sys);
		end
	endtask : ser

	// load a frame shape and wait for it to be taken
	task automatic cfg(input int l, input int a, input logic t,
			input logic s);
		lines <= 11'(l);
		act <= 9'(a);
		ten <= t;
		smart <= s;
		load <= 1'b1;
		e_len = int'(acft_pkg::FL_STROBES) + l * a
			+ (l - 1) * int'(acft_pkg::GAP_CYC);
		e_px = l * a;
		// load stands until an edge that sees the port free
		@(posedge i_clk_sys);
		for (int i = 0; i < 50 && busy; i++) @(posedge i_clk_sys);
		load <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		for (int i = 0; i < 50 && busy; i++) @(posedge i_clk_sys);
		check(busy, 1'b0);
	endtask : cfg

	// one trigger pulse, then wait for the frame when fin is set
	task automatic trig(input logic [15:0] w, input logic fin);
		treq <= 1'b1;
		tw <= w;
		// request stands until an edge that samples ready high
		@(posedge i_clk_sys);
		for (int i = 0; i < 9000 && !trdy; i++) @(posedge i_clk_sys);
		treq <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		check(trdy, 1'b0);
		check(lk.control_pairs, 4'h1);
		for (int i = 0; i < 20000 && fin && !done; i++)
			@(posedge i_clk_sys);
		check(done, fin);
	endtask : trig

	// compare every strobe on the wire and at the grabber
	always @(posedge clk_link) begin
		if (!i_rst && lk.data_valid_qualifier) begin
			check(lk.video_data, word(pix, ten));
			pix += 2;
		end
		if (!i_rst && vv) begin
			if (sof) gpix = 0;
			check(vd, word(gpix, ten));
			gpix += 2;
		end
		if (!i_rst && eof) neof++;
		if (lk.frame_valid_qualifier) begin
			flen++;
			nval += int'(lk.line_valid_qualifier);
		end else if (flen != 0) begin
			check(flen, e_len);
			check(nval, e_px);
			flen = 0;
			nval = 0;
			pix = 0;
			nfr++;
		end
	end

	// received bytes, refused triggers and the run limit
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (crv) crl <= crd;
		if (grv) grl <= grd;
		nrx <= nrx + int'(crv) + int'(grv);
		ndrop <= ndrop + int'(drop);
		if (cyc == 60000) begin
			fails++;
			close_out();
		end
	end

	initial begin
		repeat (12) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		repeat (8) @(posedge i_clk_sys);
		ser(1'b0, 8'h3C);
		ser(1'b1, 8'hA5);
		repeat (40) @(posedge i_clk_sys);
		check(crl, 8'h3C);
		check(grl, 8'hA5);
		check(nrx, 2);
		cfg(3, 4, 1'b0, 1'b0);
		trig(16'h05DC, 1'b1);
		// a trigger falling inside the overhead must be dropped
		trig(16'h05DC, 1'b0);
		// let the overhead pass before the next frame
		repeat (5500) @(posedge i_clk_sys);
		cfg(2, 1, 1'b1, 1'b1);
		trig(16'h0640, 1'b1);
		repeat (100) @(posedge i_clk_sys);
		check(nfr, 2);
		check(neof, 2);
		check(ndrop, 1);
		close_out();
	end
endmodule : area_camera_frame_output_timing_tb
